// ---- src/mst_pkg.sv ----
// Package: constants and types for the module management status block
package mst_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned T_INIT_MS      = 2000;
    localparam int unsigned T_RESET_MIN_US = 2;
    localparam int unsigned RESET_MIN_CYC  = (T_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INIT_CYC_DEF   = T_INIT_MS * 100_000;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_FLAGS   = 8'h04;
    localparam logic [7:0] REG_MASK    = 8'h08;
    localparam logic [7:0] REG_CONTROL = 8'h0C;
    localparam logic [7:0] REG_USER    = 8'h80;
    // ==========================================================
    // Field positions and reset values
    localparam int unsigned ST_NOT_READY = 0;
    localparam int unsigned ST_SELECTED  = 1;
    localparam int unsigned ST_LOW_POWER = 2;
    localparam int unsigned ST_IN_RESET  = 3;
    localparam int unsigned ST_STOPS_LSB = 8;
    localparam int unsigned CTL_PDOWN    = 0;
    localparam logic [16:0] MASK_RST     = 17'h0_0000;
    localparam logic [7:0]  STOPS_RST    = 8'h00;
    // ==========================================================
    // Types
    typedef struct packed {
        logic       ready;
        logic [3:0] other;
        logic [3:0] pad;
        logic [3:0] tx_fault;
        logic [3:0] rx_los;
    } mst_flag_type;
    typedef enum logic [1:0] {
        MST_RESET = 2'b00,
        MST_INIT  = 2'b01,
        MST_RUN   = 2'b10
    } mst_state_type;
endpackage

// ---- src/mst_top.sv ----
// Management status and timing logic of the pluggable module
`timescale 1ns/1ps
module mst_top
    import mst_pkg::*;
#(
    parameter int unsigned INIT_CYC   = INIT_CYC_DEF,
    parameter int unsigned USER_WORDS = 32
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Module pins
    input  wire logic        module_reset_n_i,
    input  wire logic        module_select_n_i,
    input  wire logic        low_power_pin_i,
    input  wire logic        bus_scl_i,
    input  wire logic        bus_sda_i,
    output logic             interrupt_out_n_o,
    // Internal conditions and controls
    input  wire logic [3:0]  rx_los_i,
    input  wire logic [3:0]  tx_fault_i,
    input  wire logic [3:0]  other_cond_i,
    output logic             bus_respond_o,
    output logic             low_power_o
);
    // ==========================================================
    // Pin synchronisers
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic [4:0] pin_raw;

    assign pin_raw = {bus_sda_i, bus_scl_i, low_power_pin_i, module_select_n_i, module_reset_n_i};

    // Reset holds the idle pin levels so no false edge follows
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_meta_q <= 5'h1B;
            pin_sync_q <= 5'h1B;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    logic rst_n_s;
    logic sel_n_s;
    logic lp_s;
    logic scl_s;
    logic sda_s;

    assign rst_n_s = pin_sync_q[0];
    assign sel_n_s = pin_sync_q[1];
    assign lp_s    = pin_sync_q[2];
    assign scl_s   = pin_sync_q[3];
    assign sda_s   = pin_sync_q[4];

    // ==========================================================
    // Serial bus stop and following falling clock
    logic       scl_q;
    logic       sda_q;
    logic       stop_seen_q;
    logic [7:0] stops_q;
    logic       stop_fall;
    logic       scl_fell;
    logic       sda_rose;
    logic       stop_cond;

    // Stop: data rises while the clock stands high
    assign scl_fell  = scl_q && !scl_s;
    assign sda_rose  = !sda_q && sda_s;
    assign stop_cond = scl_s && sda_rose;
    assign stop_fall = stop_seen_q && scl_fell;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // The stop count steps at the clock fall that follows the stop
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            stop_seen_q <= 1'b0;
        end else if (stop_cond) begin
            stop_seen_q <= 1'b1;
        end else if (stop_fall) begin
            stop_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            stops_q <= STOPS_RST;
        end else if (stop_fall) begin
            stops_q <= stops_q + 8'h01;
        end
    end

    // ==========================================================
    // Reset pulse qualification and initialisation
    // Short glitches on the reset pin are ignored on purpose
    logic [15:0]   low_cnt_q;
    logic [31:0]   init_cnt_q;
    mst_state_type state_q;
    mst_state_type state_d;
    logic          long_low;
    logic          init_done;
    logic          pin_reset;

    assign long_low  = low_cnt_q >= 16'(RESET_MIN_CYC);
    assign init_done = init_cnt_q >= INIT_CYC - 1;
    assign pin_reset = !rst_n_s && long_low;

    always_comb begin
        state_d = state_q;
        case (state_q)
            MST_RESET: begin
                if (rst_n_s) begin
                    state_d = MST_INIT;
                end
            end
            MST_INIT: begin
                if (pin_reset) begin
                    state_d = MST_RESET;
                end else if (init_done) begin
                    state_d = MST_RUN;
                end
            end
            MST_RUN: begin
                if (pin_reset) begin
                    state_d = MST_RESET;
                end
            end
            default: state_d = MST_RESET;
        endcase
    end

    // Power-on reset starts in initialisation, not in pin reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= MST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Saturates so a long hold cannot wrap into a short one
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            low_cnt_q <= 16'h0000;
        end else if (rst_n_s) begin
            low_cnt_q <= 16'h0000;
        end else if (!long_low) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            init_cnt_q <= 32'h0000_0000;
        end else if (state_q != MST_INIT) begin
            init_cnt_q <= 32'h0000_0000;
        end else begin
            init_cnt_q <= init_cnt_q + 32'h0000_0001;
        end
    end

    logic running;
    logic not_ready;

    assign running   = state_q == MST_RUN;
    assign not_ready = !running;

    // ==========================================================
    // Avalon slave handshake
    logic ack_q;
    logic req;
    logic take;

    assign req               = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = req && !ack_q;
    assign take              = req && ack_q;

    logic wr_mask;
    logic wr_ctl;
    logic wr_user;
    logic rd_flags;
    logic in_user;
    logic wr_take;
    logic rd_take;

    // Registers act only at the edge that ends the cycle with waitrequest low
    assign wr_take  = take && avs_write_i;
    assign rd_take  = take && avs_read_i;
    assign in_user  = avs_address_i >= REG_USER;
    assign wr_mask  = wr_take && avs_address_i == REG_MASK;
    assign wr_ctl   = wr_take && avs_address_i == REG_CONTROL;
    assign wr_user  = wr_take && in_user;
    assign rd_flags = rd_take && avs_address_i == REG_FLAGS;

    // ==========================================================
    // Flags, masks and interrupt
    mst_flag_type flags_q;
    mst_flag_type mask_q;
    mst_flag_type set_v;
    logic         pdown_q;
    logic         ready_q;

    always_comb begin
        set_v          = '0;
        set_v.rx_los   = rx_los_i;
        set_v.tx_fault = tx_fault_i;
        set_v.other    = other_cond_i;
        set_v.ready    = running && !ready_q;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ack_q   <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            ack_q   <= req && !ack_q;
            ready_q <= running;
        end
    end

    // Set wins over the clear-on-read in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            flags_q <= '0;
        end else if (rd_flags) begin
            flags_q <= set_v;
        end else begin
            flags_q <= flags_q | set_v;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mask_q <= MASK_RST;
        end else if (wr_mask) begin
            mask_q <= mst_flag_type'(avs_writedata_i[16:0]);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pdown_q <= 1'b0;
        end else if (wr_ctl) begin
            pdown_q <= avs_writedata_i[CTL_PDOWN];
        end
    end

    logic         irq_q;
    mst_flag_type live_v;

    assign live_v = flags_q & ~mask_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |live_v;
        end
    end

    assign interrupt_out_n_o = !irq_q;

    // ==========================================================
    // Bus gating and power
    logic resp_q;
    logic lp_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            resp_q <= 1'b0;
            lp_q   <= 1'b0;
        end else begin
            resp_q <= running && !sel_n_s;
            lp_q   <= lp_s || pdown_q;
        end
    end

    assign bus_respond_o = resp_q;
    assign low_power_o   = lp_q;

    // ==========================================================
    // User storage page, contents opaque to the block
    localparam int unsigned UW = $clog2(USER_WORDS);
    logic [31:0] user_mem [USER_WORDS];
    logic [UW-1:0] user_idx;

    assign user_idx = avs_address_i[UW+1:2];

    // No reset: the host owns the contents
    always_ff @(posedge clk_sys_i) begin
        if (wr_user) begin
            user_mem[user_idx] <= avs_writedata_i;
        end
    end

    // ==========================================================
    // Read data
    logic [31:0] status_v;
    logic [31:0] flags_word;
    logic [31:0] mask_word;
    logic [31:0] ctl_word;
    logic [31:0] user_word;
    logic [31:0] rd_v;

    assign flags_word = {15'h0000, flags_q};
    assign mask_word  = {15'h0000, mask_q};
    assign ctl_word   = {31'h0000_0000, pdown_q};
    assign user_word  = user_mem[user_idx];

    always_comb begin
        status_v                             = '0;
        status_v[ST_NOT_READY]               = not_ready;
        status_v[ST_SELECTED]                = resp_q;
        status_v[ST_LOW_POWER]               = lp_q;
        status_v[ST_IN_RESET]                = state_q == MST_RESET;
        status_v[ST_STOPS_LSB +: 8]          = stops_q;
    end

    always_comb begin
        rd_v = 32'h0000_0000;
        if (in_user) begin
            rd_v = user_word;
        end else begin
            case (avs_address_i)
                REG_STATUS:  rd_v = status_v;
                REG_FLAGS:   rd_v = flags_word;
                REG_MASK:    rd_v = mask_word;
                REG_CONTROL: rd_v = ctl_word;
                default:     rd_v = 32'h0000_0000;
            endcase
        end
    end

    // Captured in the wait cycle, stands until the next read
    logic [31:0] rdata_q;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= rd_v;
        end
    end

    assign avs_readdata_o = rdata_q;
endmodule // mst_top

// ---- verif/mst_top_asserts.sv ----
// Concurrent checks on the ports of the management status block
`timescale 1ns/1ps
module mst_top_asserts
    import mst_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    // Register bus
    input wire logic [7:0] avs_address_i,
    input wire logic       avs_read_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    // Pins and conditions
    input wire logic       interrupt_out_n_o,
    input wire logic       module_select_n_i,
    input wire logic       low_power_pin_i,
    input wire logic [3:0] rx_los_i,
    input wire logic [3:0] tx_fault_i,
    input wire logic [3:0] other_cond_i,
    input wire logic       bus_respond_o,
    input wire logic       low_power_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================================
    // Bus handshake
    sequence s_wait_ack;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    a_rd_one_wait: assert property ($rose(avs_read_i) |-> s_wait_ack)
        else $error("read wait cycle wrong");
    a_wr_one_wait: assert property ($rose(avs_write_i) |-> s_wait_ack)
        else $error("write wait cycle wrong");
    // ==========================================================
    // Interrupt and pins
    a_rst_quiet: assert property ($fell(sys_rst_i) |-> interrupt_out_n_o && !bus_respond_o && !low_power_o)
        else $error("outputs active after reset");
    a_los_irq: assert property ($rose(|rx_los_i) |-> ##[1:3] !interrupt_out_n_o)
        else $error("loss of signal not raised");
    a_fault_irq: assert property ($rose(|tx_fault_i) |-> ##[1:3] !interrupt_out_n_o)
        else $error("transmit fault not raised");
    a_other_irq: assert property ($rose(other_cond_i[3]) |-> ##[1:3] !interrupt_out_n_o)
        else $error("other condition not raised");
    // Quiet inputs needed, a live condition would re-set its flag
    a_irq_release: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == REG_FLAGS
        && !(|{rx_los_i, tx_fault_i, other_cond_i}) |-> ##[1:2] interrupt_out_n_o)
        else $error("interrupt not released");
    a_sel_off: assert property (module_select_n_i [*5] |-> !bus_respond_o)
        else $error("bus still answers");
    a_lp_pin: assert property (low_power_pin_i [*5] |-> low_power_o)
        else $error("low power not entered");
endmodule // mst_top_asserts

bind mst_top mst_top_asserts u_mst_chk (.*);

// ---- verif/mst_host_model.sv ----
// Host controller model on the 2-wire management lines
`timescale 1ns/1ps
module mst_host_model (
    input  wire logic go_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Clock stands high between frames, pulled-up data idles high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One short frame per request, link clock period 160 ns
    always @(posedge go_i) begin
        sda_o = 1'b0;
        #80;
        repeat (3) begin
            scl_o = 1'b0;
            #80 scl_o = 1'b1;
            #80;
        end
        #40 sda_o = 1'b1;
        #80 scl_o = 1'b0;
        #80 scl_o = 1'b1;
    end
endmodule // mst_host_model

// ---- verif/mst_top_tb.sv ----
// Self-checking bench for the management status block
`timescale 1ns/1ps
module mst_top_tb
    import mst_pkg::*;
;
    typedef struct packed {
        logic [3:0]  rx;
        logic [3:0]  tx;
        logic [3:0]  oc;
        logic [31:0] f;
    } mst_row_type;
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        rd_s = 1'b0, wr_s = 1'b0, rst_n = 1'b1, sel_n = 1'b1, lp = 1'b0, go = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0]  rx = 4'h0, tx = 4'h0, oc = 4'h0;
    wire logic [31:0] rdat;
    wire logic   wq, irq_n, resp, lpo, scl, sda;
    int          n_fail = 0, n_checks = 0, cyc = 0;
    mst_row_type rows [4] = '{'{4'h1, 4'h0, 4'h0, 32'h0000_0001}, '{4'h0, 4'h2, 4'h0, 32'h0000_0020},
                              '{4'h0, 4'h0, 4'h8, 32'h0000_8000}, '{4'hF, 4'hF, 4'hF, 32'h0000_F0FF}};
    // Short init count keeps the run brief
    mst_top #(.INIT_CYC(50)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .module_reset_n_i(rst_n), .module_select_n_i(sel_n), .low_power_pin_i(lp),
        .bus_scl_i(scl), .bus_sda_i(sda), .interrupt_out_n_o(irq_n), .rx_los_i(rx), .tx_fault_i(tx),
        .other_cond_i(oc), .bus_respond_o(resp), .low_power_o(lpo));
    mst_host_model HOST (.go_i(go), .scl_o(scl), .sda_o(sda));
    always #5 clk_sys_i = ~clk_sys_i;
    // ==========================================================
    // Tasks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {31'h0000_0000, e}, {31'h0000_0000, g});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Held until waitrequest is seen low; hangs are cut by the watchdog
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e, m);
        adr <= a;
        wd <= d;
        rd_s <= !w;
        wr_s <= w;
        do @(posedge clk_sys_i); while (wq !== 1'b0);
        if (!w) chk("readdata", e, rdat & m);
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    // ==========================================================
    // Sequence
    initial begin
        tick(3);
        chk1("irq", 1'b1, irq_n);
        chk1("respond", 1'b0, resp);
        sys_rst_i <= 1'b0;
        tick(1);
        bus(0, REG_STATUS, 0, 32'h0000_0001, '1);
        tick(60);
        chk1("irq", 1'b0, irq_n);
        bus(0, REG_STATUS, 0, 32'h0000_0000, '1);
        bus(0, REG_FLAGS, 0, 32'h0001_0000, '1);
        foreach (rows[i]) begin
            {rx, tx, oc} <= {rows[i].rx, rows[i].tx, rows[i].oc};
            tick(4);
            chk1("irq", 1'b0, irq_n);
            {rx, tx, oc} <= 12'h000;
            bus(0, REG_FLAGS, 0, rows[i].f, '1);
            tick(3);
            chk1("irq", 1'b1, irq_n);
        end
        bus(1, REG_MASK, 32'h0000_1000, 0, 0);
        bus(0, REG_MASK, 0, 32'h0000_1000, '1);
        oc <= 4'h1;
        tick(5);
        chk1("irq", 1'b1, irq_n);
        bus(1, REG_MASK, 0, 0, 0);
        tick(3);
        chk1("irq", 1'b0, irq_n);
        oc <= 4'h0;
        bus(0, REG_FLAGS, 0, 32'h0000_1000, '1);
        sel_n <= 1'b0;
        tick(5);
        chk1("respond", 1'b1, resp);
        bus(0, REG_STATUS, 0, 32'h0000_0002, 32'h0000_0006);
        sel_n <= 1'b1;
        tick(5);
        chk1("respond", 1'b0, resp);
        lp <= 1'b1;
        tick(5);
        chk1("low power", 1'b1, lpo);
        bus(0, REG_STATUS, 0, 32'h0000_0004, 32'h0000_0004);
        lp <= 1'b0;
        bus(1, REG_CONTROL, 32'h0000_0001, 0, 0);
        tick(2);
        chk1("low power", 1'b1, lpo);
        bus(1, REG_CONTROL, 0, 0, 0);
        tick(2);
        chk1("low power", 1'b0, lpo);
        bus(1, REG_USER + 8'h04, 32'hA5A5_5A5A, 0, 0);
        bus(0, REG_USER + 8'h04, 0, 32'hA5A5_5A5A, '1);
        bus(0, 8'h40, 0, 32'h0000_0000, '1);
        go <= 1'b1;
        tick(100);
        bus(0, REG_STATUS, 0, 32'h0000_0100, '1);
        rst_n <= 1'b0;
        tick(50);
        rst_n <= 1'b1;
        tick(4);
        bus(0, REG_STATUS, 0, 0, 32'h0000_0009);
        rst_n <= 1'b0;
        tick(250);
        bus(0, REG_STATUS, 0, 32'h0000_0008, 32'h0000_0008);
        rst_n <= 1'b1;
        tick(5);
        bus(0, REG_STATUS, 0, 32'h0000_0001, 32'h0000_0009);
        tick(60);
        chk1("irq", 1'b0, irq_n);
        tally_and_finish;
    end
endmodule // mst_top_tb
